// ===== rtl/external_pin_interrupt_unit.sv
// external pin and pin change interrupt detection, dispatch and sleep wake
`timescale 1ns/100ps
// Functional notes
// - external request zero dispatches to vector 0x001
// - external request one dispatches to vector 0x002
// - change groups zero to three dispatch to vectors 0x003 to 0x006
// - vector table ends at 0x013, serial transfer at 0x00F, twenty slots
// - pins are sensed even while driven as outputs
// - group three watches lines 27:24, group two lines 23:16
// - group one watches lines 15:8, group zero lines 7:0
// - per-pin group mask alone selects contributing lines
// - pin change detection works in every sleep mode
// - external inputs trigger on any change, falling edge, rising edge or low level
// - level mode keeps requesting while the pin stays low
// - edge detection needs the I/O clock running
// - low level detection is asynchronous and wakes from deep sleep
// - I/O clock stops in every sleep mode except idle
// - level lost before start-up end: wake, but no interrupt
// - such a wake resumes after the sleep instruction, no handler
// - sense field: 00 low, 01 any change, 10 falling, 11 rising
// - external request needs its mask and the global enable
// - edge flag sets on trigger, clears by vector or one, held clear in level
// - edge or toggle pulses longer than one clock are caught
module external_pin_interrupt_unit (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    input wire logic [27:0] pin_change_lines,
    input wire ext_irq_pkg::cfg_s cfg,
    input wire ext_irq_pkg::clr_s clr,
    input wire logic irq_ack,
    input wire logic sleep_enter,
    input wire logic sleep_idle,
    output logic irq_req,
    output logic [4:0] irq_vector,
    output ext_irq_pkg::status_s status
);
    import ext_irq_pkg::*;

    logic [NUM_LINES+1:0] raw;
    logic [NUM_LINES+1:0] syn;
    logic [NUM_LINES+1:0] changed;
    logic [NUM_GROUPS-1:0] grp_hit;
    logic [1:0] is_level;
    logic [1:0] lvl_low;
    logic [1:0] ext_hit;
    logic [NUM_SRC-1:0] ack_src;
    logic [NUM_SRC-1:0] pend;
    logic wake_src;
    state_s s_q;
    state_s s_d;

    // sense field of one external input, hi bit over lo bit
    function automatic logic [1:0] sense_of(input cfg_s c, input int idx);
        logic [1:0] r;
        r = (idx == 0) ? {c.sense_ctl_zero_hi, c.sense_ctl_zero_lo}
                       : {c.sense_ctl_one_hi, c.sense_ctl_one_lo};
        return r;
    endfunction : sense_of

    // trigger decode for the edge sense modes
    function automatic logic edge_hit(input logic [1:0] sense, input logic now, input logic was);
        logic r;
        case (sense)
            SENSE_ANY: r = now ^ was;
            SENSE_FALL: r = was & ~now;
            SENSE_RISE: r = now & ~was;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : edge_hit

    // vector address of source index, ext zero first
    function automatic logic [4:0] vec_of(input int idx);
        logic [4:0] r;
        r = VEC_EXT_ZERO + 5'(idx);
        return r;
    endfunction : vec_of

    // pad levels are sampled even when the port drives them
    assign raw = {ext_irq_pin_one, ext_irq_pin_zero, pin_change_lines};

    pin_sync2 #(
        .W(NUM_LINES + 2)
    ) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .d(raw),
        .q(syn)
    );

    // detection, flags, dispatch and power sequencing
    always_comb
    begin
        s_d = s_q;
        s_d.prev = syn;
        s_d.woke = 1'b0;
        changed = syn ^ s_q.prev;
        // change groups need no I/O clock, so they act in every sleep mode
        grp_hit[0] = |(changed[GRP1_LSB-1:GRP0_LSB] & cfg.change_group_zero_mask);
        grp_hit[1] = |(changed[GRP2_LSB-1:GRP1_LSB] & cfg.change_group_one_mask);
        grp_hit[2] = |(changed[GRP3_LSB-1:GRP2_LSB] & cfg.change_group_two_mask);
        grp_hit[3] = |(changed[NUM_LINES-1:GRP3_LSB] & cfg.change_group_three_mask);
        // ack clears only the source that is being presented
        for (int i = 0; i < NUM_SRC; i++)
        begin
            ack_src[i] = irq_ack & s_q.req & (s_q.vec == vec_of(i));
        end
        for (int i = 0; i < 2; i++)
        begin
            is_level[i] = (sense_of(cfg, i) == SENSE_LOW);
            lvl_low[i] = is_level[i] & ~syn[NUM_LINES+i];
            // edges only while the I/O clock runs; the history still tracks
            ext_hit[i] = s_q.io_run & edge_hit(sense_of(cfg, i), syn[NUM_LINES+i], s_q.prev[NUM_LINES+i]);
            // set beats clear; level mode pins the flag low
            if (is_level[i])
            begin
                s_d.eflag[i] = 1'b0;
            end
            else
            begin
                s_d.eflag[i] = ext_hit[i] | (s_q.eflag[i] & ~(clr.ext_flag_clr[i] | ack_src[i]));
            end
        end
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
            s_d.pflag[g] = grp_hit[g] | (s_q.pflag[g] & ~(clr.pc_flag_clr[g] | ack_src[2+g]));
        end
        // level requests only when awake, so a short wake level gives none
        for (int i = 0; i < 2; i++)
        begin
            pend[i] = cfg.ext_mask[i] & (is_level[i] ? (lvl_low[i] & (s_q.mode == ST_RUN)) : s_d.eflag[i]);
        end
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
            pend[2+g] = cfg.pc_enable[g] & s_d.pflag[g];
        end
        // deep sleep wakes only from the asynchronous detectors
        wake_src = |(cfg.ext_mask & is_level & lvl_low) | |(cfg.pc_enable & s_d.pflag);
        // lowest vector wins when several are pending
        s_d.req = cfg.global_ie & (|pend) & (s_q.mode == ST_RUN);
        s_d.vec = s_q.vec;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                s_d.vec = vec_of(i);
            end
        end
        // sleep, start-up and resume
        case (s_q.mode)
            ST_RUN:
            begin
                if (sleep_enter && !sleep_idle)
                begin
                    s_d.mode = ST_DEEP;
                    s_d.io_run = 1'b0;
                end
            end
            ST_DEEP:
            begin
                if (wake_src)
                begin
                    s_d.mode = ST_START;
                    s_d.cnt = '0;
                end
            end
            ST_START:
            begin
                // the wake completes even if the level has gone meanwhile
                if (s_q.cnt == STARTUP_LAST)
                begin
                    s_d.mode = ST_RUN;
                    s_d.io_run = 1'b1;
                    s_d.woke = 1'b1;
                end
                else
                begin
                    s_d.cnt = s_q.cnt + CNT_W'(1);
                end
            end
            default:
            begin
                s_d.mode = ST_RUN;
                s_d.io_run = 1'b1;
            end
        endcase
    end

    // single state register
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q <= STATE_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign irq_req = s_q.req;
    assign irq_vector = s_q.vec;
    assign status.ext_flag_one = s_q.eflag[1];
    assign status.ext_flag_zero = s_q.eflag[0];
    assign status.pc_flag = s_q.pflag;
    assign status.io_clk_run = s_q.io_run;
    assign status.asleep = (s_q.mode != ST_RUN);
    assign status.woke = s_q.woke;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_ext0_vector: assert property ((s_q.mode == ST_RUN) && cfg.global_ie && pend[0] |=> irq_req && irq_vector == 5'h01)
        else $error("ext zero not dispatched to its vector");
    a_ext1_vector: assert property ((s_q.mode == ST_RUN) && cfg.global_ie && pend[1] && !pend[0]
        |=> irq_req && irq_vector == 5'h02)
        else $error("ext one not dispatched to its vector");
    a_group_vector: assert property (irq_req |-> irq_vector >= 5'h01 && irq_vector <= 5'h06)
        else $error("group request on wrong vector");
    a_table_top: assert property (irq_req |-> irq_vector < VEC_SERIAL_XFER && irq_vector < VEC_TWO_WIRE)
        else $error("vector beyond this unit's slots");
    a_group_zero: assert property (|(changed[7:0] & cfg.change_group_zero_mask) |=> status.pc_flag[0])
        else $error("group zero change lost");
    a_group_three: assert property (|(changed[27:24] & cfg.change_group_three_mask) |=> status.pc_flag[3])
        else $error("group three change lost");
    a_mask_gate: assert property (!status.pc_flag[1] && !clr.pc_flag_clr[1]
        && !(|(changed[15:8] & cfg.change_group_one_mask)) |=> !status.pc_flag[1])
        else $error("masked line set a group flag");
    a_edge_stopped: assert property (!status.io_clk_run |=> (status.ext_flag_zero <= $past(status.ext_flag_zero)))
        else $error("edge flag set with I/O clock stopped");
    a_rise_catch: assert property (status.io_clk_run && sense_of(cfg, 0) == SENSE_RISE
        && $rose(syn[NUM_LINES]) |=> status.ext_flag_zero)
        else $error("rising edge missed");
    a_level_clear: assert property (is_level[1] |=> !status.ext_flag_one)
        else $error("flag set in level mode");
    a_level_hold: assert property (s_q.mode == ST_RUN && cfg.global_ie && cfg.ext_mask[0] && lvl_low[0]
        |=> irq_req)
        else $error("held low level not requesting");
    a_deep_stop: assert property (s_q.mode == ST_DEEP |-> !status.io_clk_run)
        else $error("I/O clock running in deep sleep");
    a_wake_start: assert property (s_q.mode == ST_DEEP && wake_src |=> s_q.mode == ST_START ##1 !irq_req)
        else $error("deep sleep wake not started");
    a_resume_quiet: assert property (s_q.mode == ST_START && !pend[0] && !pend[1] && !(|s_d.eflag) && !(|s_d.pflag)
        && s_q.cnt == STARTUP_LAST |=> status.woke && !irq_req)
        else $error("interrupt after vanished wake level");

    c_ext0_taken: cover property (irq_req && irq_vector == VEC_EXT_ZERO ##1 irq_ack);
    c_group3_taken: cover property (irq_req && irq_vector == VEC_GROUP_THREE);
    c_quiet_wake: cover property (status.woke && !irq_req);
    c_level_wake: cover property (s_q.mode == ST_DEEP && |(lvl_low & cfg.ext_mask) ##1 s_q.mode == ST_START);
endmodule : external_pin_interrupt_unit

// ===== rtl/ext_irq_pkg.sv
// shared constants, types and carriers of the external pin interrupt unit
package ext_irq_pkg;
    // line counts and widths
    localparam int NUM_LINES = 28;
    localparam int NUM_GROUPS = 4;
    localparam int NUM_SRC = 6;
    localparam int CNT_W = 10;
    // group field positions on the pin change lines
    localparam int GRP0_LSB = 0;
    localparam int GRP1_LSB = 8;
    localparam int GRP2_LSB = 16;
    localparam int GRP3_LSB = 24;
    // program vector addresses, twenty slots in all
    localparam logic [4:0] VEC_RESET = 5'h00;
    localparam logic [4:0] VEC_EXT_ZERO = 5'h01;
    localparam logic [4:0] VEC_EXT_ONE = 5'h02;
    localparam logic [4:0] VEC_GROUP_ZERO = 5'h03;
    localparam logic [4:0] VEC_GROUP_THREE = 5'h06;
    localparam logic [4:0] VEC_SERIAL_XFER = 5'h0F;
    localparam logic [4:0] VEC_TWO_WIRE = 5'h13;
    localparam int VEC_COUNT = 20;
    // sense field encodings
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_ANY = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;
    // wake-up start-up period
    localparam int CLK_PERIOD_NS = 25;
    localparam int STARTUP_TIME_NS = 16000;
    localparam int STARTUP_CYC = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_CYC - 1);

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DEEP = 2'b01,
        ST_START = 2'b10
    } power_e;

    typedef struct packed {
        logic global_ie;
        logic sense_ctl_one_hi;
        logic sense_ctl_one_lo;
        logic sense_ctl_zero_hi;
        logic sense_ctl_zero_lo;
        logic [1:0] ext_mask;
        logic [3:0] pc_enable;
        logic [3:0] change_group_three_mask;
        logic [7:0] change_group_two_mask;
        logic [7:0] change_group_one_mask;
        logic [7:0] change_group_zero_mask;
    } cfg_s;

    typedef struct packed {
        logic [1:0] ext_flag_clr;
        logic [3:0] pc_flag_clr;
    } clr_s;

    typedef struct packed {
        logic ext_flag_one;
        logic ext_flag_zero;
        logic [3:0] pc_flag;
        logic io_clk_run;
        logic asleep;
        logic woke;
    } status_s;

    typedef struct packed {
        power_e mode;
        logic [CNT_W-1:0] cnt;
        logic [NUM_LINES+1:0] prev;
        logic [1:0] eflag;
        logic [3:0] pflag;
        logic req;
        logic [4:0] vec;
        logic io_run;
        logic woke;
    } state_s;

    // reset value of the whole state
    localparam state_s STATE_RST = '{
        mode: ST_RUN,
        cnt: '0,
        prev: '1,
        eflag: 2'h0,
        pflag: 4'h0,
        req: 1'b0,
        vec: VEC_RESET,
        io_run: 1'b1,
        woke: 1'b0
    };
endpackage : ext_irq_pkg

// ===== rtl/pin_sync2.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module pin_sync2 #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= '1;
            q <= '1;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : pin_sync2

// ===== sim/ext_pins_model.sv
// model of the outside circuitry that drives the interrupt pins
`timescale 1ns/100ps
module ext_pins_model (
    input wire logic ref_clk,
    output logic ext_irq_pin_zero,
    output logic ext_irq_pin_one,
    output logic [27:0] pin_change_lines
);
    // idle high, so reset release sees no change
    initial
    begin
        ext_irq_pin_zero = 1'b1;
        ext_irq_pin_one = 1'b1;
        pin_change_lines = 28'hFFFFFFF;
    end

    // new levels at an edge, kept n cycles; any n of 1 or more spans a sampling edge, so none is missed
    task automatic drive(input logic p0, input logic p1, input logic [27:0] v, input int n);
        @(posedge ref_clk);
        ext_irq_pin_zero <= p0;
        ext_irq_pin_one <= p1;
        pin_change_lines <= v;
        repeat (n) @(posedge ref_clk);
    endtask : drive

    // wake level stays low until the caller raises it after start-up
    task automatic hold_wake_low;
        drive(1'b0, ext_irq_pin_one, pin_change_lines, 2);
    endtask : hold_wake_low
endmodule : ext_pins_model

// ===== sim/tb_top.sv
// self-checking testbench of the external pin interrupt unit
`timescale 1ns/100ps
module tb_top;
    import ext_irq_pkg::*;
    logic ref_clk, nrst, p0, p1, irq_ack, sleep_enter, sleep_idle, irq_req;
    logic [27:0] lines;
    logic [4:0] irq_vector;
    cfg_s cfg;
    clr_s clr;
    status_s status;
    int mismatches, checks;

    external_pin_interrupt_unit external_pin_interrupt_unit_i (.ref_clk(ref_clk), .nrst(nrst),
        .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1), .pin_change_lines(lines), .cfg(cfg), .clr(clr),
        .irq_ack(irq_ack), .sleep_enter(sleep_enter), .sleep_idle(sleep_idle), .irq_req(irq_req),
        .irq_vector(irq_vector), .status(status));
    ext_pins_model ext_pins_model_i (.ref_clk(ref_clk), .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1),
        .pin_change_lines(lines));

    // 40 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // one-cycle pulse: 0 ack, 1 sleep, 2 clear all flags
    task automatic pulse(input int k);
        @(posedge ref_clk);
        irq_ack <= (k == 0);
        sleep_enter <= (k == 1);
        clr <= (k == 2) ? '1 : '0;
        @(posedge ref_clk);
        irq_ack <= 1'b0;
        sleep_enter <= 1'b0;
        clr <= '0;
        #1;
    endtask : pulse

    task automatic wait_woke;
        int n;
        n = 0;
        while (status.woke !== 1'b1 && n < 800)
        begin
            tick(1);
            n++;
        end
        chk(status.woke, 1'b1, "no wake");
    endtask : wait_woke

    // every sense code on input zero, mask gating on input one
    task automatic t_sense;
        logic f;
        for (int m = 1; m < 4; m++)
        begin
            @(posedge ref_clk);
            {cfg.sense_ctl_zero_hi, cfg.sense_ctl_zero_lo} <= 2'(m);
            ext_pins_model_i.drive(1'b0, 1'b1, lines, 4);
            #1;
            f = (m != 3);
            chk(status.ext_flag_zero, f, "fall flag");
            chk(irq_req, f, "fall req");
            pulse(2);
            chk(status.ext_flag_zero, 1'b0, "clear");
            ext_pins_model_i.drive(1'b1, 1'b1, lines, 4);
            #1;
            f = (m != 2);
            chk(status.ext_flag_zero, f, "rise flag");
            if (f)
                chk(irq_vector, VEC_EXT_ZERO, "vec0");
            pulse(0);
            chk(status.ext_flag_zero, 1'b0, "ack");
        end
        @(posedge ref_clk);
        cfg.ext_mask <= 2'h1;
        {cfg.sense_ctl_one_hi, cfg.sense_ctl_one_lo} <= SENSE_FALL;
        ext_pins_model_i.drive(1'b1, 1'b0, lines, 4);
        #1;
        chk({status.ext_flag_one, irq_req}, 8'h2, "masked");
        @(posedge ref_clk);
        cfg.ext_mask <= 2'h3;
        tick(2);
        chk({irq_req, irq_vector}, {3'h1, VEC_EXT_ONE}, "vec1");
        ext_pins_model_i.drive(1'b1, 1'b1, lines, 3);
        pulse(2);
        @(posedge ref_clk);
        {cfg.sense_ctl_zero_hi, cfg.sense_ctl_zero_lo} <= SENSE_LOW;
        ext_pins_model_i.drive(1'b0, 1'b1, lines, 4);
        #1;
        chk({status.ext_flag_zero, irq_req}, 8'h1, "level");
        pulse(0);
        tick(1);
        chk(irq_req, 1'b1, "level holds");
        ext_pins_model_i.drive(1'b1, 1'b1, lines, 4);
        #1;
        chk(irq_req, 1'b0, "level gone");
        $display("t_sense done");
    endtask : t_sense

    // each group: masked line silent, enabled line flags its vector
    task automatic t_groups;
        logic [27:0] v;
        v = lines;
        @(posedge ref_clk);
        cfg.pc_enable <= 4'hF;
        {cfg.change_group_three_mask, cfg.change_group_two_mask} <= 12'hAAA;
        {cfg.change_group_one_mask, cfg.change_group_zero_mask} <= 16'hAAAA;
        for (int g = 0; g < 4; g++)
        begin
            v[g * 8] = ~v[g * 8];
            ext_pins_model_i.drive(1'b1, 1'b1, v, 4);
            #1;
            chk(status.pc_flag, 4'h0, "masked line");
            v[g * 8 + 1] = ~v[g * 8 + 1];
            ext_pins_model_i.drive(1'b1, 1'b1, v, 4);
            #1;
            chk(status.pc_flag, 8'(1 << g), "group flag");
            chk(irq_vector, VEC_GROUP_ZERO + 5'(g), "group vec");
            pulse(0);
        end
        v[9] = ~v[9];
        v[25] = ~v[25];
        ext_pins_model_i.drive(1'b1, 1'b1, v, 4);
        #1;
        chk(irq_vector, 5'h04, "first");
        pulse(0);
        chk(irq_vector, VEC_GROUP_THREE, "next");
        pulse(0);
        $display("t_groups done");
    endtask : t_groups

    // idle and deep sleep, level and change wake, early-lost level
    task automatic t_sleep;
        logic [27:0] v;
        @(posedge ref_clk);
        sleep_idle <= 1'b1;
        pulse(1);
        tick(1);
        chk({status.io_clk_run, status.asleep}, 8'h2, "idle");
        @(posedge ref_clk);
        sleep_idle <= 1'b0;
        {cfg.sense_ctl_one_hi, cfg.sense_ctl_one_lo} <= SENSE_RISE;
        pulse(1);
        tick(1);
        chk({status.io_clk_run, status.asleep}, 8'h1, "deep");
        ext_pins_model_i.drive(1'b1, 1'b0, lines, 3);
        ext_pins_model_i.drive(1'b1, 1'b1, lines, 3);
        ext_pins_model_i.hold_wake_low;
        wait_woke;
        tick(1);
        chk({irq_req, irq_vector}, {3'h1, VEC_EXT_ZERO}, "level wake");
        chk(status.io_clk_run, 1'b1, "clock back");
        chk(status.ext_flag_one, 1'b0, "no edge");
        ext_pins_model_i.drive(1'b1, 1'b1, lines, 3);
        pulse(1);
        v = lines ^ 28'h2;
        ext_pins_model_i.drive(1'b1, 1'b1, v, 2);
        wait_woke;
        tick(1);
        chk({irq_req, irq_vector}, {3'h1, VEC_GROUP_ZERO}, "change wake");
        pulse(0);
        pulse(1);
        ext_pins_model_i.drive(1'b0, 1'b1, lines, 4);
        ext_pins_model_i.drive(1'b1, 1'b1, lines, 2);
        wait_woke;
        tick(2);
        chk(irq_req, 1'b0, "early lost");
        $display("t_sleep done");
    endtask : t_sleep

    // watchdog well above the ~2100 cycles of the tests
    initial
    begin
        repeat (8000) @(posedge ref_clk);
        mismatches++;
        end_sim;
    end

    initial
    begin
        mismatches = 0;
        checks = 0;
        nrst = 1'b0;
        irq_ack = 1'b0;
        sleep_enter = 1'b0;
        sleep_idle = 1'b0;
        clr = '0;
        cfg = '0;
        cfg.global_ie = 1'b1;
        cfg.ext_mask = 2'h1;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        tick(4);
        chk({irq_req, irq_vector}, 8'h0, "reset");
        t_sense;
        t_groups;
        t_sleep;
        end_sim;
    end
endmodule : tb_top
